// file: design/fcs_pkg.sv
// constants shared by the flash command host controller
package fcs_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned ADDR_W        = 16;
   localparam int unsigned DATA_W        = 8;
   // command codes
   localparam logic [7:0] CMD_READ0      = 8'h00;
   localparam logic [7:0] CMD_READ1      = 8'hff;
   localparam logic [7:0] CMD_ERASE      = 8'h30;
   localparam logic [7:0] CMD_PROG0      = 8'h10;
   localparam logic [7:0] CMD_PROG1      = 8'h50;
   localparam logic [7:0] CMD_ID0        = 8'h80;
   localparam logic [7:0] CMD_ID1        = 8'h90;
   localparam logic [7:0] ERASED_BYTE    = 8'hff;
   localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
   localparam logic [15:0] ID_PART_ADDR  = 16'h0001;
   localparam int unsigned DONE_BIT      = 7;
   // bus timing in ns
   localparam int unsigned T_SETUP_NS    = 100;
   localparam int unsigned T_PULSE_NS    = 100;
   localparam int unsigned T_HOLD_NS     = 100;
   localparam int unsigned T_ACC_NS      = 150;
   localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] ACC_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   // user operation codes
   typedef enum logic [2:0]
   {
      OP_READ   = 3'b000,
      OP_ID     = 3'b001,
      OP_ERASE  = 3'b010,
      OP_PROG   = 3'b011,
      OP_RESET  = 3'b100
   } fcs_op_t;
endpackage : fcs_pkg

// file: design/fcs_cycle.sv
// one bus cycle on the flash pins: write strobe or read sample
`timescale 1ns/10ps
module fcs_cycle
   import fcs_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire logic              ce,
   // request
   input  wire logic              go,
   input  wire logic              wr,
   input  wire logic [15:0]       addr,
   input  wire logic [7:0]        wdata,
   output logic                   done,
   output logic [7:0]             rdata,
   // flash pins
   output logic [15:0]            flash_addr,
   output logic [7:0]             flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_i,
   output logic                   chip_select_n,
   output logic                   write_strobe_n,
   output logic                   output_enable_n
);
   typedef enum logic [1:0]
   {
      C_IDLE  = 2'b00,
      C_SETUP = 2'b01,
      C_PULSE = 2'b10,
      C_HOLD  = 2'b11
   } fcs_cst_t;

   typedef struct packed
   {
      fcs_cst_t    st;
      logic [3:0]  cnt;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic        done;
   } fcs_cyc_t;

   fcs_cyc_t q, d;

   always_comb
   begin
      d       = q;
      d.done  = 1'b0;
      d.s1    = flash_dq_i;
      d.s2    = q.s1;
      case (q.st)
         C_IDLE:
         begin
            if (go)
            begin
               d.wr    = wr;
               d.addr  = addr;
               d.wdata = wdata;
               d.cnt   = SETUP_CYC;
               d.st    = C_SETUP;
            end
         end
         C_SETUP:
         begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h1)
            begin
               // read waits access time plus the two sync stages
               d.cnt = q.wr ? PULSE_CYC : ACC_CYC + 4'h2;
               d.st  = C_PULSE;
            end
         end
         C_PULSE:
         begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h1)
            begin
               if (!q.wr)
               begin
                  d.rdata = q.s2;
               end
               d.cnt = HOLD_CYC;
               d.st  = C_HOLD;
            end
         end
         C_HOLD:
         begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h1)
            begin
               d.done = 1'b1;
               d.st   = C_IDLE;
            end
         end
         default:
         begin
            d.st = C_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   // address set before the strobe falls, data held past its rise
   assign done            = q.done;
   assign rdata           = q.rdata;
   assign flash_addr      = q.addr;
   assign flash_dq_o      = q.wdata;
   assign flash_dq_oe     = q.wr && (q.st != C_IDLE);
   assign chip_select_n   = (q.st == C_IDLE);
   assign write_strobe_n  = !(q.wr && q.st == C_PULSE);
   assign output_enable_n = !(!q.wr && q.st == C_PULSE);
endmodule : fcs_cycle

// file: design/fcs_host.sv
// host controller that drives the parallel flash command interface
`timescale 1ns/10ps
module fcs_host
   import fcs_pkg::*;
#(parameter logic [15:0] CHECK_LAST = 16'hffff)   // erase check sweeps 0 up to here
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // user request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic [2:0]        req_op,
   input  wire logic [15:0]       req_addr,
   input  wire logic [7:0]        req_data,
   input  wire logic              req_id_part,
   // user answer
   output logic                   rsp_valid,
   output logic [7:0]             rsp_data,
   output logic                   rsp_erase_bad,
   // supply control
   output logic                   program_supply,
   // flash pins
   output logic [15:0]            flash_addr,
   output logic [7:0]             flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_i,
   output logic                   chip_select_n,
   output logic                   write_strobe_n,
   output logic                   output_enable_n
);
   typedef enum logic [3:0]
   {
      H_IDLE   = 4'b0000,
      H_CMD1   = 4'b0001,
      H_CMD2   = 4'b0010,
      H_POLL   = 4'b0011,
      H_RDCMD  = 4'b0100,
      H_READ   = 4'b0101,
      H_CHECK  = 4'b0110,
      H_ANSWER = 4'b0111
   } fcs_hst_t;

   typedef struct packed
   {
      fcs_hst_t    st;
      fcs_op_t     op;
      logic [15:0] addr;
      logic [7:0]  data;
      logic [15:0] scan;
      logic        go;
      logic        wr;
      logic [15:0] caddr;
      logic [7:0]  cdata;
      logic [7:0]  rsp;
      logic        rsp_v;
      logic        bad;
   } fcs_host_t;

   fcs_host_t   q, d;
   logic        cyc_done;
   logic [7:0]  cyc_rdata;

   // true when the done bit read back shows the operation finished
   function automatic logic op_finished(input fcs_op_t op, input logic [7:0] rd,
                                        input logic [7:0] wd);
      if (op == OP_ERASE)
         op_finished = rd[DONE_BIT];
      else
         op_finished = (rd[DONE_BIT] == wd[DONE_BIT]);
   endfunction : op_finished

   function automatic logic [7:0] first_code(input fcs_op_t op);
      case (op)
         OP_ERASE: first_code = CMD_ERASE;
         OP_PROG:  first_code = CMD_PROG0;
         OP_ID:    first_code = CMD_ID1;
         default:  first_code = CMD_READ1;
      endcase
   endfunction : first_code

   always_comb
   begin
      d       = q;
      d.go    = 1'b0;
      d.rsp_v = 1'b0;
      case (q.st)
         H_IDLE:
         begin
            if (req_valid)
            begin
               d.op   = fcs_op_t'(req_op);
               d.addr = req_id_part ? ID_PART_ADDR : req_addr;
               d.data = req_data;
               d.bad  = 1'b0;
               d.wr   = 1'b1;
               d.caddr = 16'h0000;
               d.cdata = first_code(fcs_op_t'(req_op));
               d.go   = 1'b1;
               d.st   = H_CMD1;
            end
         end
         H_CMD1:
         begin
            if (cyc_done)
            begin
               d.go = 1'b1;
               case (q.op)
                  OP_ERASE:
                  begin
                     d.cdata = CMD_ERASE;
                     d.st    = H_CMD2;
                  end
                  OP_PROG:
                  begin
                     d.caddr = q.addr;
                     d.cdata = q.data;
                     d.st    = H_CMD2;
                  end
                  OP_RESET:
                  begin
                     d.cdata = CMD_READ1;
                     d.st    = H_CMD2;
                  end
                  default:
                  begin
                     d.wr    = 1'b0;
                     d.caddr = q.addr;
                     d.st    = H_READ;
                  end
               endcase
            end
         end
         H_CMD2:
         begin
            if (cyc_done)
            begin
               if (q.op == OP_RESET)
               begin
                  d.rsp_v = 1'b1;
                  d.st    = H_IDLE;
               end
               else
               begin
                  // device times the operation; host only polls
                  d.go    = 1'b1;
                  d.wr    = 1'b0;
                  d.caddr = q.addr;
                  d.st    = H_POLL;
               end
            end
         end
         H_POLL:
         begin
            if (cyc_done)
            begin
               d.go = 1'b1;
               if (op_finished(q.op, cyc_rdata, q.data))
               begin
                  d.rsp  = cyc_rdata;
                  d.scan = 16'h0000;
                  d.caddr = 16'h0000;
                  d.st   = (q.op == OP_ERASE) ? H_CHECK : H_ANSWER;
                  d.go   = (q.op == OP_ERASE);
               end
            end
         end
         H_CHECK:
         begin
            if (cyc_done)
            begin
               if (cyc_rdata != ERASED_BYTE)
               begin
                  d.bad = 1'b1;
               end
               d.scan  = q.scan + 16'h0001;
               d.caddr = q.scan + 16'h0001;
               d.go    = (q.scan != CHECK_LAST);
               d.st    = (q.scan != CHECK_LAST) ? H_CHECK : H_ANSWER;
            end
         end
         H_READ:
         begin
            if (cyc_done)
            begin
               d.rsp = cyc_rdata;
               d.st  = H_ANSWER;
            end
         end
         H_ANSWER:
         begin
            d.rsp_v = 1'b1;
            d.st    = H_IDLE;
         end
         default:
         begin
            d.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else if (clk_en)
      begin
         q <= d;
      end
   end

   fcs_cycle u_cycle
   (
      .mclk            (mclk),
      .sys_rst         (sys_rst),
      .ce              (clk_en),
      .go              (q.go),
      .wr              (q.wr),
      .addr            (q.caddr),
      .wdata           (q.cdata),
      .done            (cyc_done),
      .rdata           (cyc_rdata),
      .flash_addr      (flash_addr),
      .flash_dq_o      (flash_dq_o),
      .flash_dq_oe     (flash_dq_oe),
      .flash_dq_i      (flash_dq_i),
      .chip_select_n   (chip_select_n),
      .write_strobe_n  (write_strobe_n),
      .output_enable_n (output_enable_n)
   );

   // supply stays up after reset so commands are taken; the device
   // falls back to reading while it is low, so none are issued then
   assign program_supply = 1'b1;
   assign req_ready      = (q.st == H_IDLE);
   assign rsp_valid      = q.rsp_v;
   assign rsp_data       = q.rsp;
   assign rsp_erase_bad  = q.bad;

   property p_setup_second;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && q.st == H_CMD1 && cyc_done && q.op == OP_ERASE) |=>
         (q.cdata == CMD_ERASE && q.st == H_CMD2);
   endproperty
   a_setup_second: assert property (p_setup_second) else $error("erase second code");

   property p_prog_data;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && q.st == H_CMD1 && cyc_done && q.op == OP_PROG) |=>
         (q.cdata == q.data && q.caddr == q.addr);
   endproperty
   a_prog_data: assert property (p_prog_data) else $error("program write wrong");

   property p_poll_read;
      @(posedge mclk) disable iff (sys_rst)
      (q.st == H_POLL) |-> (flash_dq_oe == 1'b0 || chip_select_n);
   endproperty
   a_poll_read: assert property (p_poll_read) else $error("host drove bus during poll");

   property p_strobe_sep;
      @(posedge mclk) disable iff (sys_rst)
      $fell(write_strobe_n) |-> output_enable_n && !chip_select_n && flash_dq_oe;
   endproperty
   a_strobe_sep: assert property (p_strobe_sep) else $error("strobe without select");

   property p_data_hold;
      @(posedge mclk) disable iff (sys_rst)
      $rose(write_strobe_n) |-> !chip_select_n && $stable(flash_dq_o);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data not held");

   property p_reset_two;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && q.st == H_CMD1 && cyc_done && q.op == OP_RESET) |=>
         (q.cdata == CMD_READ1);
   endproperty
   a_reset_two: assert property (p_reset_two) else $error("reset not repeated");

   property p_erase_done;
      @(posedge mclk) disable iff (sys_rst)
      (clk_en && q.st == H_POLL && cyc_done && q.op == OP_ERASE && !cyc_rdata[DONE_BIT])
         |=> (q.st == H_POLL);
   endproperty
   a_erase_done: assert property (p_erase_done) else $error("erase left early");

   property p_supply;
      @(posedge mclk) disable iff (sys_rst)
      !chip_select_n |-> program_supply;
   endproperty
   a_supply: assert property (p_supply) else $error("access with supply low");
endmodule : fcs_host

// file: verification/fcs_flash_model.sv
// behavioural flash device answering the host controller's pin cycles
`timescale 1ns/10ps
module fcs_flash_model
   import fcs_pkg::*;
#(
   parameter int unsigned PROG_NS  = 2000,
   parameter int unsigned ERASE_NS = 20000,
   parameter logic [7:0]  MAKER_ID = 8'h5a,   // arbitrary value
   parameter logic [7:0]  PART_ID  = 8'h3c    // arbitrary value
)
(
   // supply
   input  wire logic        program_supply,
   // pins
   input  wire logic [15:0] flash_addr,
   input  wire logic [7:0]  dq_in,
   output logic [7:0]       dq_out,
   input  wire logic        chip_select_n,
   input  wire logic        write_strobe_n,
   input  wire logic        output_enable_n
);
   typedef enum logic [2:0] {FM_READ, FM_ID, FM_ESET, FM_PSET, FM_PBUSY, FM_EBUSY} fcs_fm_t;
   logic [7:0]  mem [0:65535];
   fcs_fm_t     st = FM_READ;
   logic        in_write = 1'b0;
   logic [15:0] lat_addr;
   logic [15:0] prog_addr;
   logic [7:0]  prog_byte;
   logic [7:0]  drv;
   logic [7:0]  last = 8'h00;

   initial
      foreach (mem[i]) mem[i] = ERASED_BYTE;

   // any supply transition drops a pending command
   always @(program_supply)
      if (st != FM_PBUSY && st != FM_EBUSY) st = FM_READ;

   // address follows the later falling edge of select and strobe
   always @(negedge chip_select_n or negedge write_strobe_n)
      if (!chip_select_n && !write_strobe_n && output_enable_n && program_supply)
      begin
         lat_addr = flash_addr;
         in_write = 1'b1;
      end

   // data follows the earlier rising edge; writes while busy are dropped
   always @(posedge chip_select_n or posedge write_strobe_n)
      if (in_write)
      begin
         in_write = 1'b0;
         if (st == FM_PSET)
         begin
            prog_addr = lat_addr;
            prog_byte = dq_in;
            st = FM_PBUSY;
         end
         else if (st == FM_ESET && dq_in == CMD_ERASE)
            st = FM_EBUSY;
         else if (st != FM_PBUSY && st != FM_EBUSY)
            case (dq_in)
               CMD_ID0, CMD_ID1:     st = FM_ID;
               CMD_ERASE:            st = FM_ESET;
               CMD_PROG0, CMD_PROG1: st = FM_PSET;
               default:              st = FM_READ;
            endcase
      end

   // internal timing; programming only clears bits, and erase zeroes every cell before setting it back to erased
   always @(st)
      if (st == FM_PBUSY)
      begin
         #(PROG_NS);
         mem[prog_addr] = mem[prog_addr] & prog_byte;
         st = FM_READ;
      end
      else if (st == FM_EBUSY)
      begin
         #(ERASE_NS);
         foreach (mem[i]) mem[i] = 8'h00;
         foreach (mem[i]) mem[i] = ERASED_BYTE;
         st = FM_READ;
      end

   always @*
      case (st)
         FM_PBUSY: drv = {~prog_byte[7], mem[flash_addr][6:0]};
         FM_EBUSY: drv = 8'h4c;
         FM_ID:    drv = (flash_addr == ID_MAKER_ADDR) ? MAKER_ID :
                         (flash_addr == ID_PART_ADDR) ? PART_ID : mem[flash_addr];
         default:  drv = mem[flash_addr];
      endcase

   // a released bus shows the inverse of its last value, not a held copy
   always @*
      if (!chip_select_n && !output_enable_n) last = drv;
   assign dq_out = (!chip_select_n && !output_enable_n) ? drv : ~last;
endmodule : fcs_flash_model

// file: verification/fcs_host_tb.sv
// self-checking bench for the flash host controller against a device model
`timescale 1ns/10ps
module fcs_host_tb
   import fcs_pkg::*;
;
   localparam int unsigned MAX_CYC  = 20000;
   // a short erase sweep keeps the run small; the full array would take ~820k cycles with the random stalls
   localparam logic [15:0] CHECK_LAST = 16'h003f;
   localparam logic [7:0]  MAKER_ID = 8'h5a;   // arbitrary value
   localparam logic [7:0]  PART_ID  = 8'h3c;   // arbitrary value
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        clk_en = 1'b1;
   logic        req_valid = 1'b0;
   logic [2:0]  req_op = 3'h0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0]  req_data = 8'h00;
   logic        req_id_part = 1'b0;
   logic        req_ready, rsp_valid, rsp_erase_bad, program_supply;
   logic [7:0]  rsp_data, flash_dq_o, flash_dq_i, dev_dq;
   logic [15:0] flash_addr;
   logic        flash_dq_oe, chip_select_n, write_strobe_n, output_enable_n;
   logic [8:0]  exp_q [$];
   logic [8:0]  note;
   logic [7:0]  shadow [logic [15:0]];
   logic [15:0] a;
   logic [7:0]  d;
   logic        rsp_prev = 1'b0;
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;

   always #25 mclk = ~mclk;
   assign flash_dq_i = flash_dq_oe ? flash_dq_o : dev_dq;

   fcs_host #(.CHECK_LAST(CHECK_LAST)) dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .req_id_part(req_id_part), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_erase_bad(rsp_erase_bad), .program_supply(program_supply),
      .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
      .flash_dq_i(flash_dq_i), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n));

   fcs_flash_model #(.PROG_NS(2000), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) fm (
      .program_supply(program_supply), .flash_addr(flash_addr), .dq_in(flash_dq_i),
      .dq_out(dev_dq), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .output_enable_n(output_enable_n));

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // bit 8 of the note says whether the answer byte is compared
   task automatic request(input logic [2:0] op, input logic [15:0] ad, input logic [7:0] dt,
                          input logic part, input logic [8:0] exp);
      exp_q.push_back(exp);
      @(negedge mclk);
      req_valid = 1'b1;
      req_op = op;
      req_addr = ad;
      req_data = dt;
      req_id_part = part;
      do
         @(posedge mclk);
      while (!(clk_en === 1'b1 && req_ready === 1'b1));
      @(negedge mclk);
      req_valid = 1'b0;
   endtask : request

   task automatic test_end(input string name);
      while (exp_q.size() != 0)
         @(posedge mclk);
      $display("test %s done, checks %0d mismatches %0d", name, num_checks, err_total);
   endtask : test_end

   // stall the controller at random (one cycle in eight on average) so bus phases get stretched at random points
   always @(negedge mclk)
      if (!sys_rst) clk_en <= ($urandom % 8) != 0;

   always @(posedge mclk)
   begin
      cyc++;
      if (rsp_valid === 1'b1 && rsp_prev !== 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            err_total++;
            $display("wrong value at %0t: answer with nothing expected", $time);
         end
         else
         begin
            note = exp_q.pop_front();
            if (note[8]) check(rsp_data, note[7:0], "answer byte");
         end
      end
      rsp_prev = rsp_valid;
      if (cyc >= MAX_CYC)
      begin
         err_total++;
         $display("wrong value at %0t: run did not finish", $time);
         report_and_stop();
      end
   end

   initial
   begin
      void'($urandom(24736));
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      check({7'h00, program_supply}, 8'h01, "supply enable");
      for (int i = 0; i < 4; i++)
         request(OP_READ, 16'($urandom), 8'h00, 1'b0, {1'b1, ERASED_BYTE});
      test_end("read");
      request(OP_ID, ID_MAKER_ADDR, 8'h00, 1'b0, {1'b1, MAKER_ID});
      request(OP_ID, 16'hbeef, 8'h00, 1'b1, {1'b1, PART_ID});
      request(OP_READ, ID_PART_ADDR, 8'h00, 1'b0, {1'b1, ERASED_BYTE});
      test_end("identify");
      for (int i = 0; i < 6; i++)
      begin
         a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'(16'h1000 + i * 16'h0111);
         d = 8'($urandom);
         shadow[a] = d;
         request(OP_PROG, a, d, 1'b0, {1'b1, d});
      end
      d = 8'($urandom) & 8'h7f;
      shadow[16'h0000] = shadow[16'h0000] & d;
      request(OP_PROG, 16'h0000, d, 1'b0, {1'b1, shadow[16'h0000]});
      shadow[16'h2000] = ERASED_BYTE;
      request(OP_PROG, 16'h2000, ERASED_BYTE, 1'b0, {1'b1, ERASED_BYTE});
      foreach (shadow[k])
         request(OP_READ, k, 8'h00, 1'b0, {1'b1, shadow[k]});
      test_end("program");
      request(OP_ID, ID_MAKER_ADDR, 8'h00, 1'b0, {1'b1, MAKER_ID});
      request(OP_RESET, 16'h0000, 8'h00, 1'b0, 9'h000);
      request(OP_READ, 16'h0000, 8'h00, 1'b0, {1'b1, shadow[16'h0000]});
      test_end("reset");
      request(OP_ERASE, 16'($urandom), 8'h00, 1'b0, {1'b1, ERASED_BYTE});
      test_end("erase");
      check({7'h00, rsp_erase_bad}, 8'h00, "erase check flag");
      foreach (shadow[k])
         request(OP_READ, k, 8'h00, 1'b0, {1'b1, ERASED_BYTE});
      test_end("after erase");
      report_and_stop();
   end
endmodule : fcs_host_tb
